// [rtl/heater_check.sv]
// heater current capture and burnout decision for one channel
`timescale 1ns/1ps
module heater_check
	import hsad_pkg::*;
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          ctrl_on,
	input  wire logic [15:0]   on_ms,
	input  wire logic          on_end,
	input  wire logic [15:0]   min_on_ms,
	input  wire logic          cur_valid,
	input  wire logic [CW-1:0] cur_sample,
	input  wire logic          cur_over,
	input  wire logic [THW-1:0] thr,
	output logic               burn,
	output logic               hold,
	output logic               exceed,
	output logic      [CW-1:0] heater_cur
);
	logic          on_ok;
	logic          take;
	logic          over;
	logic [CW-1:0] meas;

	// measure only past the least on time
	assign on_ok = on_ms > min_on_ms;
	assign take = cur_valid && ctrl_on && on_ok;
	// clamp at the measurement range top
	assign over = cur_over || (cur_sample > CUR_TOP);
	assign meas = over ? CUR_TOP : cur_sample;

	// publish current sampled while output on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			heater_cur <= '0;
			exceed <= 1'b0;
		end
		else if (take)
		begin
			heater_cur <= meas;
			exceed <= over;
		end
	end

	// too short an on time keeps last value
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hold <= 1'b0;
		else if (on_end && !on_ok)
			hold <= 1'b1;
		else if (take)
			hold <= 1'b0;
	end

	// zero forces clear, top forces set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			burn <= 1'b0;
		else if (thr == THR_DEF)
			burn <= 1'b0;
		else if (thr == THR_MAX)
			burn <= 1'b1;
		else if (!ctrl_on)
			burn <= 1'b0;
		else if (take)
			burn <= meas <= CW'(thr);
	end
endmodule

// [rtl/heater_sensor_alarm_detect.sv]
// per-channel sensor disconnection and heater burnout detector, APB slave
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module heater_sensor_alarm_detect
	import hsad_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [7:0]                   paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	output logic                              irq,
	input  wire logic                         temp_valid,
	input  wire logic [NUM_CH-1:0][TW-1:0]    temp_raw,
	input  wire logic [NUM_CH-1:0]            sensor_open,
	input  wire logic [NUM_CH-1:0]            ctrl_on,
	input  wire logic [NUM_CH-1:0]            cur_valid,
	input  wire logic [NUM_CH-1:0][CW-1:0]    cur_sample,
	input  wire logic [NUM_CH-1:0]            cur_over,
	input  wire logic                         io_thr_wr,
	input  wire logic [1:0]                   io_thr_ch,
	input  wire logic [THW-1:0]               io_thr_data,
	output logic      [NUM_CH-1:0][THW-1:0]   io_thr,
	output logic      [NUM_CH-1:0][TW-1:0]    temp_out,
	output logic      [NUM_CH-1:0][CW-1:0]    heater_cur,
	output logic      [NUM_CH-1:0][ST_W-1:0]  alarm_status,
	output logic      [NUM_CH-1:0]            heater_drive,
	output logic      [NUM_CH-1:0]            evt_disc,
	output logic      [NUM_CH-1:0]            evt_burn
);
	// ==========================================================
	// declarations
	logic                       wr_acc;
	logic                       rd_acc;
	logic                       addr_hit;
	logic [31:0]                next_rdata;
	logic                       filt_en;
	logic [15:0]                period_pend;
	logic [15:0]                period_act;
	logic [15:0]                min_on_ms;
	logic [2*NUM_CH-1:0]        int_stat;
	logic [2*NUM_CH-1:0]        int_mask;
	logic [2*NUM_CH-1:0]        int_set;
	logic [31:0]                evt_code;
	logic [15:0]                ms_cnt;
	logic                       ms_tick;
	logic [NUM_CH-1:0]          disc;
	logic [NUM_CH-1:0]          disc_q;
	logic [NUM_CH-1:0]          burn;
	logic [NUM_CH-1:0]          burn_q;
	logic [NUM_CH-1:0]          hold;
	logic [NUM_CH-1:0]          exceed;
	logic [NUM_CH-1:0][TW-1:0]  temp_filt;
	logic [NUM_CH-1:0][TW-1:0]  temp_last;
	logic [NUM_CH-1:0][15:0]    on_ms;
	logic [NUM_CH-1:0]          on_end;
	logic [1:0]                 ch_sel;

	// ==========================================================
	// apb handshake
	// refused addresses must not land a write anywhere
	assign wr_acc = psel && penable && pwrite && addr_hit;
	assign rd_acc = psel && penable && !pwrite;
	assign ch_sel = paddr[3:2];
	// zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_hit;

	// ==========================================================
	// control and restart-applied period
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filt_en <= 1'b0;
		else if (wr_acc && paddr == ADDR_CTRL)
			filt_en <= pwdata[CTRL_FILT_BIT];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_pend <= PERIOD_DEF_MS;
		else if (wr_acc && paddr == ADDR_PERIOD)
			period_pend <= pwdata[15:0];
	end

	// pending period only takes effect on restart
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_act <= PERIOD_DEF_MS;
		else if (wr_acc && paddr == ADDR_CTRL && pwdata[CTRL_RESTART_BIT])
			period_act <= period_pend;
	end

	// least on time from the control period
	always_comb
	begin
		if (period_act <= PERIOD_SHORT_MS)
			min_on_ms = MIN_ON_SHORT_MS;
		else
			min_on_ms = MIN_ON_LONG_MS;
	end

	// ==========================================================
	// millisecond time base shared by all channels
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ms_cnt <= 16'h0000;
		else if (ms_tick)
			ms_cnt <= 16'h0000;
		else
			ms_cnt <= ms_cnt + 16'h0001;
	end

	assign ms_tick = ms_cnt == 16'(MS_CYCLES - 1);

	// ==========================================================
	// thresholds: apb wins over the cyclic path in the same cycle
	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gen_thr
			// clamp to 50 A, applies at once
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					io_thr[g] <= THR_DEF;
				else if (wr_acc && paddr[7:4] == BASE_THR && ch_sel == 2'(g))
					io_thr[g] <= (pwdata[THW-1:0] > THR_MAX || |pwdata[31:THW])
						? THR_MAX : pwdata[THW-1:0];
				else if (io_thr_wr && io_thr_ch == 2'(g))
					io_thr[g] <= (io_thr_data > THR_MAX) ? THR_MAX : io_thr_data;
			end
		end
	endgenerate

	// ==========================================================
	// per-channel temperature path
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gen_temp
			// range check on the raw sample
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					disc[g] <= 1'b0;
				else if (temp_valid)
					// clears once the sample is good again
					disc[g] <= sensor_open[g]
						|| ($signed(temp_raw[g]) > TEMP_IND_HI)
						|| ($signed(temp_raw[g]) < TEMP_IND_LO);
			end

			// first-order smoothing; the shift trades lag for noise
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					temp_filt[g] <= '0;
					temp_last[g] <= '0;
				end
				else if (temp_valid)
				begin
					temp_last[g] <= temp_raw[g];
					temp_filt[g] <= TW'($signed(temp_filt[g])
						+ (($signed({temp_raw[g][TW-1], temp_raw[g]})
						- $signed({temp_filt[g][TW-1], temp_filt[g]}))
						>>> FILT_SHIFT));
				end
			end

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					temp_out[g] <= '0;
				else if (disc[g])
					temp_out[g] <= TEMP_IND_HI;
				else if (filt_en)
					temp_out[g] <= temp_filt[g];
				else
					temp_out[g] <= temp_last[g];
			end
		end
	endgenerate

	// ==========================================================
	// per-channel heater path
	// each channel owns its timer and checker
	generate
		for (g = 0; g < NUM_CH; g++)
		begin : gen_heat
			ontime_timer u_timer (
				.pclk    (pclk),
				.presetn (presetn),
				.ms_tick (ms_tick),
				.ctrl_on (ctrl_on[g]),
				.on_ms   (on_ms[g]),
				.on_end  (on_end[g])
			);

			// late heater power reads as no current
			heater_check u_check (
				.pclk       (pclk),
				.presetn    (presetn),
				.ctrl_on    (ctrl_on[g]),
				.on_ms      (on_ms[g]),
				.on_end     (on_end[g]),
				.min_on_ms  (min_on_ms),
				.cur_valid  (cur_valid[g]),
				.cur_sample (cur_sample[g]),
				.cur_over   (cur_over[g]),
				.thr        (io_thr[g]),
				.burn       (burn[g]),
				.hold       (hold[g]),
				.exceed     (exceed[g]),
				.heater_cur (heater_cur[g])
			);

			assign alarm_status[g][ST_DISC] = disc[g];
			assign alarm_status[g][ST_BURN] = burn[g];
			assign alarm_status[g][ST_HOLD] = hold[g];
			assign alarm_status[g][ST_EXCEED] = exceed[g];
		end
	endgenerate

	// output passes on whatever the alarms say
	assign heater_drive = ctrl_on;

	// ==========================================================
	// events
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			disc_q <= '0;
			burn_q <= '0;
		end
		else
		begin
			disc_q <= disc;
			burn_q <= burn;
		end
	end

	// disconnection event on the rising flag
	assign evt_disc = disc & ~disc_q;
	// burnout event on the rising flag
	assign evt_burn = burn & ~burn_q;
	assign int_set = {evt_burn, evt_disc};

	// newest event code; disconnection outranks burnout when together
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			evt_code <= 32'h00000000;
		else if (|evt_disc)
			evt_code <= EVT_DISC_CODE;
		else if (|evt_burn)
			evt_code <= EVT_BURN_CODE;
	end

	// ==========================================================
	// interrupt status, mask and line
	// read clears, but an event in the same cycle survives
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_stat <= '0;
		else if (rd_acc && paddr == ADDR_INT_STAT)
			int_stat <= int_set;
		else
			int_stat <= int_stat | int_set;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_mask <= '0;
		else if (wr_acc && paddr == ADDR_INT_MASK)
			int_mask <= pwdata[2*NUM_CH-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= |((int_stat | int_set) & int_mask);
	end

	// ==========================================================
	// read mux, captured in the setup cycle
	always_comb
	begin
		next_rdata = 32'h00000000;
		addr_hit = 1'b1;
		case (paddr[7:4])
			BASE_THR:
				next_rdata[THW-1:0] = io_thr[ch_sel];
			BASE_CUR:
				next_rdata[CW-1:0] = heater_cur[ch_sel];
			BASE_TEMP:
				next_rdata = {{(32-TW){temp_out[ch_sel][TW-1]}},
					temp_out[ch_sel]};
			default:
			begin
				case (paddr)
					ADDR_CTRL:
						next_rdata[CTRL_FILT_BIT] = filt_en;
					ADDR_PERIOD:
						next_rdata[15:0] = period_pend;
					ADDR_PERIOD_ACT:
						next_rdata[15:0] = period_act;
					ADDR_STATUS:
						next_rdata[NUM_CH*ST_W-1:0] = alarm_status;
					ADDR_INT_STAT:
						next_rdata[2*NUM_CH-1:0] = int_stat;
					ADDR_INT_MASK:
						next_rdata[2*NUM_CH-1:0] = int_mask;
					ADDR_EVT_CODE:
						next_rdata = evt_code;
					default:
						addr_hit = 1'b0;
				endcase
			end
		endcase
		if (paddr[1:0] != 2'b00)
			addr_hit = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (psel && !penable)
			prdata <= next_rdata;
	end
endmodule

// [rtl/hsad_pkg.sv]
// constants shared by the heater and sensor alarm detector
package hsad_pkg;
	// ==========================================================
	// structure
	localparam int NUM_CH = 4;
	localparam int TW = 16;
	localparam int CW = 16;
	localparam int THW = 10;
	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int MS_TIME_NS = 1000000;
	localparam int MS_CYCLES_DEF = MS_TIME_NS / CLK_PERIOD_NS;
	localparam logic [15:0] PERIOD_LONG_MS = 16'h01f4;
	localparam logic [15:0] PERIOD_SHORT_MS = 16'h00c8;
	localparam logic [15:0] MIN_ON_LONG_MS = 16'h0064;
	localparam logic [15:0] MIN_ON_SHORT_MS = 16'h001e;
	localparam logic [15:0] PERIOD_DEF_MS = 16'h07d0;
	// ==========================================================
	// ranges, in 0.1 units, and the filter shift
	localparam logic signed [TW-1:0] TEMP_IND_HI = 16'h1388;
	localparam logic signed [TW-1:0] TEMP_IND_LO = 16'hf830;
	localparam logic [CW-1:0] CUR_TOP = 16'h01f4;
	localparam logic [THW-1:0] THR_MAX = 10'h1f4;
	localparam logic [THW-1:0] THR_DEF = 10'h000;
	localparam int FILT_SHIFT = 2;
	// ==========================================================
	// event codes
	localparam logic [31:0] EVT_DISC_CODE = 32'h65100000;
	localparam logic [31:0] EVT_BURN_CODE = 32'h652c0000;
	// ==========================================================
	// register map
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_PERIOD_ACT = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_INT_STAT = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;
	localparam logic [7:0] ADDR_EVT_CODE = 8'h18;
	localparam logic [3:0] BASE_THR = 4'h2;
	localparam logic [3:0] BASE_CUR = 4'h3;
	localparam logic [3:0] BASE_TEMP = 4'h4;
	localparam int CTRL_FILT_BIT = 0;
	localparam int CTRL_RESTART_BIT = 1;
	localparam int ST_DISC = 0;
	localparam int ST_BURN = 1;
	localparam int ST_HOLD = 2;
	localparam int ST_EXCEED = 3;
	localparam int ST_W = 4;
endpackage

// [rtl/ontime_timer.sv]
// measures how long a channel control output has been on, in ms
`timescale 1ns/1ps
module ontime_timer
	import hsad_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ms_tick,
	input  wire logic        ctrl_on,
	output logic      [15:0] on_ms,
	output logic             on_end
);
	logic ctrl_on_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_on_q <= 1'b0;
		else
			ctrl_on_q <= ctrl_on;
	end

	// count restarts at each rising edge, holds after the falling one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_ms <= 16'h0000;
		else if (ctrl_on && !ctrl_on_q)
			on_ms <= 16'h0000;
		else if (ctrl_on && ms_tick && on_ms != 16'hffff)
			on_ms <= on_ms + 16'h0001;
	end

	assign on_end = ctrl_on_q && !ctrl_on;
endmodule

// [verification/heater_sensor_alarm_detect_bench.sv]
// self-checking bench for the heater and sensor alarm detector
`timescale 1ns/1ps
`define CHK(a, b) \
	begin n_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("unexpected at %0t: %h vs %h", $time, a, b); end end
module heater_sensor_alarm_detect_bench
	import hsad_pkg::*;
;
	localparam int MSC = 10;
	logic	pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic	temp_valid, io_thr_wr;
	logic	[7:0] paddr;
	logic	[31:0] pwdata, prdata, r;
	logic	[1:0] io_thr_ch;
	logic	[THW-1:0] io_thr_data, t1;
	logic	[NUM_CH-1:0][TW-1:0] temp_set, temp_raw, temp_out;
	logic	[NUM_CH-1:0][CW-1:0] cur_set, cur_sample, heater_cur;
	logic	[NUM_CH-1:0][THW-1:0] io_thr;
	logic	[NUM_CH-1:0][ST_W-1:0] alarm_status;
	logic	[NUM_CH-1:0] open_set, over_set, sensor_open, ctrl_on, cur_valid;
	logic	[NUM_CH-1:0] cur_over, heater_drive, evt_disc, evt_burn;
	int	miscompares, n_checks;

	heater_sensor_alarm_detect #(.MS_CYCLES(MSC)) dut_u (.pclk, .presetn,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .temp_valid, .temp_raw, .sensor_open, .ctrl_on,
		.cur_valid, .cur_sample, .cur_over, .io_thr_wr, .io_thr_ch,
		.io_thr_data, .io_thr, .temp_out, .heater_cur, .alarm_status,
		.heater_drive, .evt_disc, .evt_burn);
	hsad_front_model front_u (.pclk, .presetn, .temp_set, .open_set,
		.cur_set, .over_set, .temp_valid, .temp_raw, .sensor_open,
		.cur_valid, .cur_sample, .cur_over);

	initial pclk = 1'b0;
	always #12.5 pclk = ~pclk;
	// ==========
	// expectations
	function automatic logic [TW-1:0] exp_temp(logic [TW-1:0] v, logic o);
		if (o || $signed(v) > TEMP_IND_HI || $signed(v) < TEMP_IND_LO)
			return TEMP_IND_HI;
		return v;
	endfunction
	function automatic logic exp_burn(logic [CW-1:0] c, logic [THW-1:0] t);
		return t == THR_MAX || (t != '0 && c <= CW'(t));
	endfunction
	// ==========
	// bus and run control
	task automatic close_out;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (i = 0; pready !== 1'b1; i++)
		begin
			if (i == 50)
			begin
				miscompares++;
				close_out;
			end
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		`CHK(r, x)
	endtask
	task automatic chk_temps;
		for (int c = 0; c < NUM_CH; c++)
			`CHK(temp_out[c], exp_temp(temp_set[c], open_set[c]))
	endtask
	// ==========
	// main sequence
	initial
	begin
		{psel, penable, pwrite, io_thr_wr, paddr, pwdata} = '0;
		{temp_set, open_set, cur_set, over_set, ctrl_on} = '0;
		{io_thr_ch, io_thr_data, miscompares, n_checks} = '0;
		presetn = 1'b0;
		void'($urandom(32'h68e6));
		cyc(5);
		presetn <= 1'b1;
		for (int c = 0; c < NUM_CH; c++)
			temp_set[c] <= (c == 2) ? 16'h0 : 16'($urandom_range(1000));
		cyc(1);
		rd(ADDR_PERIOD_ACT, {16'h0, PERIOD_DEF_MS});
		rd({BASE_THR, 4'h0}, 32'h0);
		apb(1'b0, 8'h1c, 32'h0);
		`CHK(e, 1'b1)
		apb(1'b1, ADDR_PERIOD, 32'hc8);
		rd(ADDR_PERIOD_ACT, {16'h0, PERIOD_DEF_MS});
		apb(1'b1, ADDR_CTRL, 32'h2);
		rd(ADDR_PERIOD_ACT, 32'hc8);
		apb(1'b1, ADDR_INT_MASK, 32'h1);
		open_set[0] <= 1'b1;
		cyc(20);
		`CHK(temp_out[0], TEMP_IND_HI)
		`CHK(alarm_status[0][ST_DISC], 1'b1)
		`CHK(irq, 1'b1)
		rd(ADDR_EVT_CODE, EVT_DISC_CODE);
		rd(ADDR_INT_STAT, 32'h1);
		rd(ADDR_INT_STAT, 32'h0);
		open_set[0] <= 1'b0;
		temp_set[1] <= 16'h2000;
		cyc(20);
		chk_temps;
		`CHK(alarm_status[0][ST_DISC], 1'b0)
		`CHK(irq, 1'b0)
		// filter on, one spike must still be caught on the raw sample
		apb(1'b1, ADDR_CTRL, 32'h1);
		temp_set[2] <= 16'h2000;
		cyc(12);
		`CHK(alarm_status[2][ST_DISC], 1'b1)
		temp_set[2] <= 16'h0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		t1 = THW'($urandom_range(499, 1));
		io_thr_ch <= 2'h1;
		io_thr_data <= t1;
		io_thr_wr <= 1'b1;
		cyc(1);
		io_thr_wr <= 1'b0;
		apb(1'b1, {BASE_THR, 4'h0}, 32'h64);
		apb(1'b1, {BASE_THR, 4'hc}, 32'h3ff);
		rd({BASE_THR, 4'hc}, 32'h1f4);
		`CHK(io_thr[1], t1)
		cur_set[0] <= 16'h32;
		cur_set[1] <= CW'(t1) + 16'($urandom_range(500 - t1, 1));
		ctrl_on <= 4'h3;
		cyc(200);
		`CHK(alarm_status[0][ST_BURN], 1'b0)
		cyc(200);
		`CHK(alarm_status[0][ST_BURN], exp_burn(cur_set[0], 10'h64))
		`CHK(alarm_status[1][ST_BURN], exp_burn(cur_set[1], t1))
		`CHK(heater_cur[1], cur_set[1])
		`CHK(alarm_status[3][ST_BURN], 1'b1)
		rd(ADDR_EVT_CODE, EVT_BURN_CODE);
		ctrl_on[0] <= 1'b0;
		cyc(2);
		`CHK(alarm_status[0][ST_BURN], 1'b0)
		cur_set[0] <= 16'h46;
		ctrl_on[0] <= 1'b1;
		cyc(100);
		ctrl_on[0] <= 1'b0;
		cyc(3);
		`CHK(alarm_status[0][ST_HOLD], 1'b1)
		`CHK(heater_cur[0], 16'h32)
		over_set[0] <= 1'b1;
		ctrl_on[0] <= 1'b1;
		cyc(400);
		`CHK(alarm_status[0][ST_EXCEED], 1'b1)
		`CHK(heater_cur[0], CUR_TOP)
		`CHK(heater_drive, ctrl_on)
		// long control period needs the 100 ms least on time
		apb(1'b1, ADDR_PERIOD, 32'h1f4);
		apb(1'b1, ADDR_CTRL, 32'h2);
		cur_set[1] <= 16'h0;
		ctrl_on[1] <= 1'b0;
		cyc(2);
		ctrl_on[1] <= 1'b1;
		cyc(700);
		`CHK(alarm_status[1][ST_BURN], 1'b0)
		cyc(400);
		`CHK(alarm_status[1][ST_BURN], exp_burn(16'h0, t1))
		close_out;
	end
endmodule

bind heater_sensor_alarm_detect heater_sensor_alarm_detect_properties
	#(.MS_CYCLES(MS_CYCLES)) prop_u (.pclk, .presetn, .temp_valid,
	.temp_raw, .sensor_open, .ctrl_on, .io_thr, .temp_out, .heater_cur,
	.alarm_status, .heater_drive, .evt_disc, .evt_burn);

// [verification/heater_sensor_alarm_detect_properties.sv]
// concurrent checks on the detector's ports
`timescale 1ns/1ps
module heater_sensor_alarm_detect_properties
	import hsad_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
)
(
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire logic                         temp_valid,
	input wire logic [NUM_CH-1:0][TW-1:0]    temp_raw,
	input wire logic [NUM_CH-1:0]            sensor_open,
	input wire logic [NUM_CH-1:0]            ctrl_on,
	input wire logic [NUM_CH-1:0][THW-1:0]   io_thr,
	input wire logic [NUM_CH-1:0][TW-1:0]    temp_out,
	input wire logic [NUM_CH-1:0][CW-1:0]    heater_cur,
	input wire logic [NUM_CH-1:0][ST_W-1:0]  alarm_status,
	input wire logic [NUM_CH-1:0]            heater_drive,
	input wire logic [NUM_CH-1:0]            evt_disc,
	input wire logic [NUM_CH-1:0]            evt_burn
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========
	// sensor side
	sequence open_s;
		temp_valid && sensor_open[0];
	endsequence
	sequence good_s;
		temp_valid && !sensor_open[0] && $signed(temp_raw[0]) <= TEMP_IND_HI
			&& $signed(temp_raw[0]) >= TEMP_IND_LO;
	endsequence
	disc_set_a: assert property (open_s |=> alarm_status[0][ST_DISC])
		else $error("disconnect flag missing");
	disc_clear_a: assert property (good_s |=> !alarm_status[0][ST_DISC])
		else $error("disconnect flag stuck");
	temp_clamp_a: assert property (
		open_s |=> ##1 temp_out[0] == TEMP_IND_HI)
		else $error("open sensor value not clamped");
	disc_event_a: assert property (
		evt_disc[0] == $rose(alarm_status[0][ST_DISC]))
		else $error("disconnect event mistimed");
	// ==========
	// heater side
	burn_event_a: assert property (
		evt_burn[0] == $rose(alarm_status[0][ST_BURN]))
		else $error("burnout event mistimed");
	burn_off_a: assert property (
		!ctrl_on[0] && io_thr[0] != THR_MAX |=> !alarm_status[0][ST_BURN])
		else $error("burnout flag while output off");
	thr_zero_a: assert property (
		io_thr[2] == '0 |=> !alarm_status[2][ST_BURN])
		else $error("zero threshold raised burnout");
	thr_full_a: assert property (
		io_thr[3] == THR_MAX |=> alarm_status[3][ST_BURN])
		else $error("full threshold left burnout clear");
	exceed_top_a: assert property (
		alarm_status[0][ST_EXCEED] |-> heater_cur[0] == CUR_TOP)
		else $error("over range current not clamped");
	drive_pass_a: assert property (heater_drive == ctrl_on)
		else $error("control output disturbed");
endmodule

// [verification/hsad_front_model.sv]
// sensor and current transformer front end driving the detector
`timescale 1ns/1ps
module hsad_front_model
	import hsad_pkg::*;
(
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic [NUM_CH-1:0][TW-1:0] temp_set,
	input  wire logic [NUM_CH-1:0]         open_set,
	input  wire logic [NUM_CH-1:0][CW-1:0] cur_set,
	input  wire logic [NUM_CH-1:0]         over_set,
	output logic                           temp_valid,
	output logic      [NUM_CH-1:0][TW-1:0] temp_raw,
	output logic      [NUM_CH-1:0]         sensor_open,
	output logic      [NUM_CH-1:0]         cur_valid,
	output logic      [NUM_CH-1:0][CW-1:0] cur_sample,
	output logic      [NUM_CH-1:0]         cur_over
);
	logic	[2:0]	tick;
	logic		t_now;
	logic		c_now;
	// ==========
	// sample pacing: temperature every 8 cycles, current every 4
	assign t_now = (tick == 3'h7);
	assign c_now = (tick[1:0] == 2'h3);
	// lines carry inverted data between samples, never a stale copy
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			tick <= 3'h0;
			{temp_valid, temp_raw, sensor_open} <= '0;
			{cur_valid, cur_sample, cur_over} <= '0;
		end
		else
		begin
			tick <= tick + 3'h1;
			temp_valid <= t_now;
			temp_raw <= t_now ? temp_set : ~temp_set;
			sensor_open <= t_now ? open_set : ~open_set;
			cur_valid <= {NUM_CH{c_now}};
			cur_sample <= c_now ? cur_set : ~cur_set;
			cur_over <= c_now ? over_set : ~over_set;
		end
endmodule
